//--- common/glvs_pkg.sv
// Shared constants and types for the gray-shade pixel fetch and lookup block
`default_nettype none

package glvs_pkg;

	// -----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL     = 6'h01;  // Mode and start strobe
	localparam logic [5:0] IDX_STATUS   = 6'h02;  // Busy and current line
	localparam logic [5:0] IDX_START    = 6'h03;  // Frame start word offset
	localparam logic [5:0] IDX_HDISP    = 6'h04;  // Displayed words per line
	localparam logic [5:0] IDX_LINES    = 6'h05;  // Lines per frame
	localparam logic [5:0] IDX_VLINES   = 6'h06;  // Virtual lines available
	localparam logic [5:0] IDX_EXTRA    = 6'h11;  // line_extra_words
	localparam logic [5:0] IDX_PAL_BASE = 6'h20;  // First palette_table entry

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int CTRL_MODE4_BIT  = 0;   // 0: 2 bpp gray, 1: 4 bpp gray
	localparam int CTRL_GO_BIT     = 1;   // Write 1 starts a frame
	localparam int STAT_BUSY_BIT   = 0;   // Fetch engine running
	localparam int STAT_LINE_LSB   = 16;  // Current line number
	localparam int PAL_GREEN_LSB   = 4;   // Green intensity nibble position

	// -----------------------------------------------------------------
	// Sizes and reset values
	// -----------------------------------------------------------------
	localparam int          PAL_ENTRIES = 16;        // Entries reachable in gray modes
	localparam int          WORD_W      = 16;        // Display memory word width
	localparam int          FIFO_DEPTH  = 4;         // Fetched words in flight
	localparam logic [16:0] BUF_BYTES   = 17'h14000; // 81920-byte display buffer
	localparam logic [7:0]  EXTRA_RST   = 8'h00;     // No virtual width
	localparam logic [7:0]  HDISP_RST   = 8'h00;     // Words per line
	localparam logic [9:0]  LINES_RST   = 10'h000;   // Lines per frame
	localparam logic [16:0] START_RST   = 17'h00000; // Frame start
	localparam logic [1:0]  RESP_OKAY   = 2'h0;      // AXI okay answer
	localparam logic [1:0]  RESP_SLVERR = 2'h2;      // AXI unmapped answer

	// Fetch engine states
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,  // Waiting for start
		FS_REQ  = 2'b01,  // Offering a word address
		FS_WAIT = 2'b10,  // Waiting for read data
		FS_PUSH = 2'b11   // Handing word to the FIFO
	} glvs_fetch_type;

endpackage

`default_nettype wire

//--- core/glvs_top.sv
// Gray-shade pixel fetch, unpack and palette lookup with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------------
// Word FIFO
// -------------------------------------------------------------------------
module glvs_fifo #(
	parameter int WIDTH = 16,  // Word width
	parameter int DEPTH = 4    // Number of words
) (
	input  wire logic             aclk,       // Clock
	input  wire logic             aresetn,    // Synchronous reset, low
	input  wire logic             in_valid,   // Word offered
	output logic                  in_ready,   // Room for a word
	input  wire logic [WIDTH-1:0] in_data,    // Word in
	output logic                  out_valid,  // Word available
	input  wire logic             out_ready,  // Word taken
	output logic      [WIDTH-1:0] out_data    // Word out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
	logic [PW-1:0]    wr_ptr_reg;     // Write slot
	logic [PW-1:0]    rd_ptr_reg;     // Read slot
	logic [CW-1:0]    count_reg;      // Words held
	logic             push, pop;      // Transfers this cycle

	assign in_ready  = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_q[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
			end
			count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_fifo_no_overfill: assert property (count_reg <= CW'(DEPTH))
		else $error("fifo count above depth");
endmodule // glvs_fifo

// -------------------------------------------------------------------------
// Contract
// - 2 bpp codes 0..3 pick entries 0..3
// - 2 bpp: four pixels per byte
// - 2 bpp ignores entries beyond four
// - 4 bpp nibble indexes first sixteen entries
// - 4 bpp: two pixels per byte
// - Each entry holds one of sixteen levels
// - Hold 8-bit line extra word count
// - Extra count accepts 0 to 255
// - Zero extra means no virtual width
// - Displayed words come from display width
// - Buffer 81920 bytes; report virtual lines
// - Green only; no 8 bpp gray
// - Start setting is frame word offset
// -------------------------------------------------------------------------
module glvs_top
(
	input  wire logic        aclk,            // Clock, 40 MHz
	input  wire logic        aresetn,         // Synchronous reset, low
	input  wire logic        s_axi_awvalid,   // Write address valid
	output logic             s_axi_awready,   // Write address ready
	input  wire logic [7:0]  s_axi_awaddr,    // Write byte address
	input  wire logic [2:0]  s_axi_awprot,    // Unused protection
	input  wire logic        s_axi_wvalid,    // Write data valid
	output logic             s_axi_wready,    // Write data ready
	input  wire logic [31:0] s_axi_wdata,     // Write data
	input  wire logic [3:0]  s_axi_wstrb,     // Byte enables
	output logic             s_axi_bvalid,    // Write answer valid
	input  wire logic        s_axi_bready,    // Write answer taken
	output logic [1:0]       s_axi_bresp,     // Write answer code
	input  wire logic        s_axi_arvalid,   // Read address valid
	output logic             s_axi_arready,   // Read address ready
	input  wire logic [7:0]  s_axi_araddr,    // Read byte address
	input  wire logic [2:0]  s_axi_arprot,    // Unused protection
	output logic             s_axi_rvalid,    // Read answer valid
	input  wire logic        s_axi_rready,    // Read answer taken
	output logic [31:0]      s_axi_rdata,     // Read data
	output logic [1:0]       s_axi_rresp,     // Read answer code
	output logic             mem_rd_valid,    // Word address offered
	input  wire logic        mem_rd_ready,    // Word address taken
	output logic [16:0]      mem_rd_addr,     // Display buffer word address
	input  wire logic        mem_rdata_valid, // Read word returns
	input  wire logic [15:0] mem_rdata,       // Read word, low byte first
	output logic             pix_valid,       // Pixel available
	input  wire logic        pix_ready,       // Pixel taken
	output logic [3:0]       pix_gray         // Gray intensity
);
	import glvs_pkg::*;

	// ---------------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------------
	logic                  aw_held_reg, w_held_reg;  // Write halves caught
	logic [5:0]            aw_idx_reg;               // Write index
	logic [31:0]           w_data_reg;               // Write data
	logic [3:0]            w_strb_reg;               // Write enables
	logic                  bvalid_reg, rvalid_reg;   // Answers pending
	logic [1:0]            bresp_reg, rresp_reg;     // Answer codes
	logic [31:0]           rdata_reg;                // Read data
	logic                  wr_fire;                  // Write performed
	logic                  wr_ok;                    // Write to a mapped register
	logic                  mode4_reg;                // 4 bpp selected
	logic [16:0]           start_reg;                // Frame start word
	logic [7:0]            hdisp_reg;                // Words shown per line
	logic [7:0]            extra_reg;                // line_extra_words
	logic [9:0]            lines_reg;                // Lines per frame
	logic [3:0]            pal_q [PAL_ENTRIES];      // palette_table green
	logic                  go;                       // Start strobe
	glvs_fetch_type        state_reg;                // Fetch state
	logic [16:0]           line_start_reg;           // Current line start
	logic [16:0]           addr_reg;                 // Word address out
	logic [7:0]            word_cnt_reg;             // Word within line
	logic [9:0]            line_cnt_reg;             // Line within frame
	logic [15:0]           fetched_reg;              // Word awaiting FIFO
	logic                  fifo_in_ready;            // FIFO has room
	logic                  fifo_out_valid;           // FIFO has word
	logic [15:0]           fifo_out_data;            // FIFO head
	logic                  word_valid_reg;           // Unpack word held
	logic [15:0]           word_reg;                 // Unpack word
	logic [2:0]            sub_reg;                  // Pixel within word
	logic                  pix_valid_reg;            // Output pixel valid
	logic [3:0]            pix_gray_reg;             // Output intensity
	logic                  pix_load;                 // New pixel loaded
	logic [16:0]           vlines;                   // Virtual lines

	// Decode: index of a mapped register, else not ok
	function automatic logic reg_ok(input logic [7:0] a);
		logic [5:0] i;
		i = a[7:2];
		return (a[1:0] == 2'b00) && (i == IDX_CTRL || i == IDX_STATUS || i == IDX_START ||
			i == IDX_HDISP || i == IDX_LINES || i == IDX_VLINES || i == IDX_EXTRA ||
			(i >= IDX_PAL_BASE && i < 6'(IDX_PAL_BASE + PAL_ENTRIES)));
	endfunction

	// Byte-lane merge of new data into old
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
		end
		return r;
	endfunction

	// Palette index of one pixel: low byte first, leftmost pixel in high bits
	function automatic logic [3:0] pix_index(input logic [15:0] w, input logic [2:0] s,
		input logic m4);
		logic [7:0] b;
		b = (m4 ? s[1] : s[2]) ? w[15:8] : w[7:0];
		if (m4) return s[0] ? b[3:0] : b[7:4];
		return {2'b00, 2'(b >> (3'd6 - {s[1:0], 1'b0}))};
	endfunction

	// ---------------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------------
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign wr_fire       = aw_held_reg && w_held_reg;
	assign wr_ok         = wr_fire && (bresp_reg == RESP_OKAY);  // Unmapped writes change nothing

	// Write channel: catch address and data in either order, then answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_idx_reg  <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[7:2];
				bresp_reg   <= reg_ok(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Virtual lines that fit the buffer at the present line pitch
	always_comb begin
		logic [9:0] pitch;
		pitch  = 10'(hdisp_reg) + 10'(extra_reg);
		vlines = (pitch == '0) ? '0 : 17'(BUF_BYTES / {pitch, 1'b0});
	end

	// Read channel: one registered answer per address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= reg_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_reg  <= '0;
			unique case (reg_ok(s_axi_araddr) ? s_axi_araddr[7:2] : 6'h00)  // Unmapped reads return zero
				IDX_CTRL:   rdata_reg[CTRL_MODE4_BIT] <= mode4_reg;
				IDX_STATUS: begin
					rdata_reg[STAT_BUSY_BIT]               <= (state_reg != FS_IDLE);
					rdata_reg[STAT_LINE_LSB +: 10]         <= line_cnt_reg;
				end
				IDX_START:  rdata_reg[16:0] <= start_reg;
				IDX_HDISP:  rdata_reg[7:0]  <= hdisp_reg;
				IDX_LINES:  rdata_reg[9:0]  <= lines_reg;
				IDX_VLINES: rdata_reg[16:0] <= vlines;
				IDX_EXTRA:  rdata_reg[7:0]  <= extra_reg;
				default: begin
					if (reg_ok(s_axi_araddr)) begin
						rdata_reg[PAL_GREEN_LSB +: 4] <= pal_q[4'(s_axi_araddr[7:2] - IDX_PAL_BASE)];
					end
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------------
	// Registers steering the block
	// ---------------------------------------------------------------------
	assign go = wr_ok && (aw_idx_reg == IDX_CTRL) && w_strb_reg[0] && w_data_reg[CTRL_GO_BIT];

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode4_reg <= 1'b0;
			start_reg <= START_RST;
			hdisp_reg <= HDISP_RST;
			extra_reg <= EXTRA_RST;
			lines_reg <= LINES_RST;
		end else if (wr_ok) begin
			unique case (aw_idx_reg)
				IDX_CTRL:  if (w_strb_reg[0]) mode4_reg <= w_data_reg[CTRL_MODE4_BIT];
				IDX_START: start_reg <= 17'(merge({15'h0000, start_reg}, w_data_reg, w_strb_reg));
				IDX_HDISP: hdisp_reg <= 8'(merge({24'h000000, hdisp_reg}, w_data_reg, w_strb_reg));
				IDX_EXTRA: extra_reg <= 8'(merge({24'h000000, extra_reg}, w_data_reg, w_strb_reg));
				IDX_LINES: lines_reg <= 10'(merge({22'h000000, lines_reg}, w_data_reg, w_strb_reg));
				default: ;
			endcase
		end
	end

	// Palette: only the green nibble of the first sixteen entries is held
	always_ff @(posedge aclk) begin
		if (wr_ok && w_strb_reg[0] && aw_idx_reg >= IDX_PAL_BASE &&
			aw_idx_reg < 6'(IDX_PAL_BASE + PAL_ENTRIES)) begin
			pal_q[4'(aw_idx_reg - IDX_PAL_BASE)] <= w_data_reg[PAL_GREEN_LSB +: 4];
		end
	end

	// ---------------------------------------------------------------------
	// Fetch engine
	// ---------------------------------------------------------------------
	assign mem_rd_valid = (state_reg == FS_REQ);
	assign mem_rd_addr  = addr_reg;

	// Walk the lines of a frame one word at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg      <= FS_IDLE;
			line_start_reg <= '0;
			addr_reg       <= '0;
			word_cnt_reg   <= '0;
			line_cnt_reg   <= '0;
			fetched_reg    <= '0;
		end else begin
			unique case (state_reg)
				FS_IDLE: begin
					if (go && hdisp_reg != '0 && lines_reg != '0) begin
						line_start_reg <= start_reg;
						addr_reg       <= start_reg;
						word_cnt_reg   <= '0;
						line_cnt_reg   <= '0;
						state_reg      <= FS_REQ;
					end
				end
				FS_REQ:  if (mem_rd_ready) state_reg <= FS_WAIT;
				FS_WAIT: begin
					if (mem_rdata_valid) begin
						fetched_reg <= mem_rdata;
						state_reg   <= FS_PUSH;
					end
				end
				FS_PUSH: begin
					if (fifo_in_ready) begin
						state_reg <= FS_REQ;
						if (word_cnt_reg == 8'(hdisp_reg - 1'b1)) begin
							word_cnt_reg   <= '0;
							line_start_reg <= 17'(line_start_reg + hdisp_reg + extra_reg);
							addr_reg       <= 17'(line_start_reg + hdisp_reg + extra_reg);
							line_cnt_reg   <= 10'(line_cnt_reg + 1'b1);
							if (line_cnt_reg == 10'(lines_reg - 1'b1)) state_reg <= FS_IDLE;
						end else begin
							word_cnt_reg <= 8'(word_cnt_reg + 1'b1);
							addr_reg     <= 17'(line_start_reg + word_cnt_reg + 1'b1);
						end
					end
				end
			endcase
		end
	end

	glvs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (state_reg == FS_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (fetched_reg),
		.out_valid (fifo_out_valid),
		.out_ready (!word_valid_reg),
		.out_data  (fifo_out_data)
	);

	// ---------------------------------------------------------------------
	// Unpack and lookup
	// ---------------------------------------------------------------------
	assign pix_load  = word_valid_reg && (!pix_valid_reg || pix_ready);
	assign pix_valid = pix_valid_reg;
	assign pix_gray  = pix_gray_reg;

	// Split each word into eight or four pixels and map through green
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_valid_reg <= 1'b0;
			word_reg       <= '0;
			sub_reg        <= '0;
			pix_valid_reg  <= 1'b0;
			pix_gray_reg   <= '0;
		end else begin
			if (!word_valid_reg && fifo_out_valid) begin
				word_valid_reg <= 1'b1;
				word_reg       <= fifo_out_data;
				sub_reg        <= '0;
			end
			if (pix_load) begin
				pix_valid_reg <= 1'b1;
				pix_gray_reg  <= pal_q[pix_index(word_reg, sub_reg, mode4_reg)];
				sub_reg       <= 3'(sub_reg + 1'b1);
				if (sub_reg == (mode4_reg ? 3'd3 : 3'd7)) word_valid_reg <= 1'b0;
			end else if (pix_ready) begin
				pix_valid_reg <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------
	default clocking cb2 @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_gray2_lookup: assert property (pix_load && !mode4_reg |=>
		pix_gray_reg == $past(pal_q[{2'b00, 2'(pix_index(word_reg, sub_reg, 1'b0))}]))
		else $error("2 bpp pixel not from first four entries");
	a_gray2_range: assert property (pix_load && !mode4_reg |=> pix_gray_reg == $past(pal_q[{2'b00,
		word_reg[{sub_reg[2], ~sub_reg[1:0], 1'b1}], word_reg[{sub_reg[2], ~sub_reg[1:0], 1'b0}]}]))
		else $error("2 bpp pixel not from its pair's entry");
	a_word_eight: assert property (pix_load && !mode4_reg && sub_reg == 3'd7 |=> !word_valid_reg)
		else $error("2 bpp word not released after eight pixels");
	a_gray4_lookup: assert property (pix_load && mode4_reg |=>
		pix_gray_reg == $past(pal_q[pix_index(word_reg, sub_reg, 1'b1)]))
		else $error("4 bpp pixel lookup wrong");
	a_word_four: assert property (word_valid_reg && mode4_reg && $stable(mode4_reg) |-> sub_reg <= 3'd3)
		else $error("4 bpp word used beyond four pixels");
	a_palette_store: assert property (wr_ok && w_strb_reg[0] && aw_idx_reg == IDX_PAL_BASE |=>
		pal_q[0] == $past(w_data_reg[PAL_GREEN_LSB +: 4]))
		else $error("palette entry not stored");
	a_extra_store: assert property (wr_ok && aw_idx_reg == IDX_EXTRA && w_strb_reg[0] |=>
		extra_reg == $past(w_data_reg[7:0]))
		else $error("extra word count not stored");
	a_line_pitch: assert property (state_reg == FS_PUSH && fifo_in_ready &&
		word_cnt_reg == 8'(hdisp_reg - 1'b1) |=>
		line_start_reg == 17'($past(line_start_reg) + $past(hdisp_reg) + $past(extra_reg)))
		else $error("next line start wrong");
	a_no_virtual: assert property (state_reg == FS_PUSH && fifo_in_ready && extra_reg == '0 &&
		word_cnt_reg == 8'(hdisp_reg - 1'b1) |=> addr_reg == 17'($past(addr_reg) + 1'b1))
		else $error("zero extra still skips words");
	a_frame_start: assert property (state_reg == FS_IDLE && go && hdisp_reg != '0 && lines_reg != '0 |=>
		mem_rd_valid && mem_rd_addr == $past(start_reg))
		else $error("frame does not begin at start offset");
	a_word_addr: assert property (state_reg == FS_REQ |->
		addr_reg == 17'(line_start_reg + word_cnt_reg) && word_cnt_reg < hdisp_reg)
		else $error("word address outside displayed width");
	a_vlines_value: assert property (hdisp_reg == 8'd80 && extra_reg == 8'd0 |-> vlines == 17'd512)
		else $error("virtual line count wrong");

	c_frame_done: cover property (state_reg == FS_PUSH ##1 state_reg == FS_IDLE);
	c_fifo_full: cover property (state_reg == FS_PUSH && !fifo_in_ready);
	c_pix_4bpp: cover property (pix_load && mode4_reg);
	c_virtual_line: cover property (state_reg == FS_PUSH && fifo_in_ready && extra_reg != '0 &&
		word_cnt_reg == 8'(hdisp_reg - 1'b1));
endmodule // glvs_top

`default_nettype wire

//--- testbench/glvs_mem_model.sv
// Display buffer memory model answering word reads at mixed latency
`timescale 1ns/1ps
`default_nettype none
module glvs_mem_model (
	input  wire logic        aclk,            // Clock
	input  wire logic        aresetn,         // Synchronous reset, low
	input  wire logic        mem_rd_valid,    // Word address offered
	output logic             mem_rd_ready,    // Address taken every other cycle
	input  wire logic [16:0] mem_rd_addr,     // Word address
	output logic             mem_rdata_valid, // One-cycle data pulse
	output logic      [15:0] mem_rdata        // Word, toggles between answers
);
	logic [16:0] addr_reg; // Captured address
	logic [1:0]  wait_reg; // Cycles left before the answer
	// Odd addresses answer a cycle later; between answers the data bus inverts every cycle
	always_ff @(posedge aclk) begin
		mem_rdata_valid <= 1'b0;
		mem_rdata       <= ~mem_rdata;
		if (!aresetn) begin
			mem_rd_ready <= 1'b0;
			wait_reg     <= 2'h0;
			mem_rdata    <= 16'h5A3C;
		end else begin
			mem_rd_ready <= ~mem_rd_ready;
			if (mem_rd_valid && mem_rd_ready) begin
				addr_reg <= mem_rd_addr;
				wait_reg <= mem_rd_addr[0] ? 2'h2 : 2'h1;
			end else if (wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
				if (wait_reg == 2'h1) begin
					mem_rdata_valid <= 1'b1;
					mem_rdata       <= addr_reg[15:0] * 16'h9E37 ^ {15'h0, addr_reg[16]};
				end
			end
		end
	end
endmodule // glvs_mem_model
`default_nettype wire

//--- testbench/glvs_top_tb.sv
// Self-checking bench for the gray-shade fetch and lookup block
`timescale 1ns/1ps
`default_nettype none
module glvs_top_tb;
	import glvs_pkg::*;
	// ---------------------------------------------------------------
	// Signals, models and the design
	// ---------------------------------------------------------------
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, pix_ready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_rd_valid, mem_rd_ready, mem_rdata_valid, pix_valid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hA7EF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [16:0] mem_rd_addr;
	logic [15:0] mem_rdata;
	logic [3:0] pix_gray, pal [16], exp_q [$];
	int num_errors = 0, cmp_count = 0, cycles = 0;
	always #12.5 aclk = ~aclk;
	glvs_top dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr,
		.mem_rdata_valid, .mem_rdata, .pix_valid, .pix_ready, .pix_gray);
	glvs_mem_model mem_u (.aclk, .aresetn, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr, .mem_rdata_valid, .mem_rdata);
	// ---------------------------------------------------------------
	// Helpers: random source, compare, verdict, bus cycles
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp; s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
	endtask
	// Program one frame, build its expected pixels, start it and drain it
	task automatic frame(input logic m4, input logic [16:0] st, input logic [7:0] hd, ex, input logic [9:0] ln);
		logic [1:0] r; logic [15:0] w; logic [7:0] b; logic [31:0] d;
		wr(8'h0C, {15'h0, st}, r); wr(8'h10, {24'h0, hd}, r); wr(8'h14, {22'h0, ln}, r); wr(8'h44, {24'h0, ex}, r);
		rd(8'h44, d, r); chk(d, {24'h0, ex});
		rd(8'h18, d, r); chk(d, 32'(81920 / (2 * (hd + ex))));
		for (int k = 0; k < ln; k++) for (int i = 0; i < hd; i++) begin
			w = 16'(17'(st + k * (hd + ex) + i) * 16'h9E37) ^ {15'h0, 17'(st + k * (hd + ex) + i) >> 16};
			for (int j = 0; j < 2; j++) begin
				b = j ? w[15:8] : w[7:0];
				if (m4) begin exp_q.push_back(pal[b[7:4]]); exp_q.push_back(pal[b[3:0]]); end
				else for (int p = 3; p >= 0; p--) exp_q.push_back(pal[{2'h0, b[2*p +: 2]}]);
			end
		end
		wr(8'h04, {30'h0, 1'b1, m4}, r);
		for (int t = 0; t < 4000 && exp_q.size() > 0; t++) @(posedge aclk);
		chk(exp_q.size(), 0);
		do rd(8'h08, d, r); while (d[0] !== 1'b0);
	endtask
	// Pixel sink with random stalls, pixel comparison and the run limit
	always @(posedge aclk) begin
		pix_ready <= rnd() % 4 != 0;
		if (pix_valid && pix_ready) chk(pix_gray, exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
		if (++cycles == 30000) begin num_errors++; end_sim(); end
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [1:0] r; logic [31:0] d;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rd(8'h44, d, r); chk(d, {24'h0, EXTRA_RST});
		for (int e = 0; e < 16; e++) begin
			d = rnd(); pal[e] = d[7:4];
			wr(8'(8'h80 + 4 * e), d, r); chk(r, RESP_OKAY);
			rd(8'(8'h80 + 4 * e), d, r); chk(d, {24'h0, pal[e], 4'h0});
		end
		wr(8'hFC, 32'hFF, r); chk(r, RESP_SLVERR);
		frame(1'b0, 17'h00005, 8'h02, 8'h03, 10'h003);
		frame(1'b1, 17'h1FFFE, 8'h03, 8'h00, 10'h002);
		frame(1'b1, 17'h00010, 8'h01, 8'hFF, 10'h002);
		rd(8'h46, d, r); chk(d, 32'h0); chk(r, RESP_SLVERR);
		wr(8'h45, 32'h0, r); chk(r, RESP_SLVERR); rd(8'h44, d, r); chk(d, 32'hFF);
		wr(8'h10, 32'h50, r); wr(8'h44, 32'h0, r); rd(8'h18, d, r); chk(d, 32'h200);
		end_sim();
	end
endmodule // glvs_top_tb
`default_nettype wire
